// ==== core/dmofd_top.v ====
// Operand field decoder for data-move and immediate instructions
// Notes on behaviour
// - Reverse flag: 0 normal, 1 bit-reversed update
// - Low field is 16-bit data or address
// - Upper byte is top 8 of 24
// - Immediate is upper byte over low field
// - Direct selector valid only when pointer zero
// - Direct selector codes map to I/O registers
// - Direction: 0 memory to register, 1 reverse
`timescale 1ns/1ps
`default_nettype none
`include "dmofd_map.vh"
module dmofd_top
(
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        insn_valid,
  input  wire [31:0] insn_word,
  output reg         dec_valid,
  output reg         bit_reversed,
  output reg         to_memory,
  output reg  [15:0] low_imm,
  output reg  [7:0]  upper_immediate_byte,
  output reg  [23:0] imm24,
  output reg         direct_mode,
  output reg         sel_in_buf,
  output reg         sel_out_buf,
  output reg         sel_par_data,
  output reg         sel_par_ptr,
  output reg         sel_second_parallel_data_reg,
  output reg         sel_par_int,
  output reg         sel_ctrl_word,
  output reg         sel_debug,
  output reg         sel_reserved,
  output reg  [4:0]  ptr_num,
  output reg         ptr_zero,
  output reg         ptr_step_down,
  output reg         ptr_step_up,
  output reg         ptr_reserved
);
  wire [4:0]  ptr_field;
  wire [4:0]  ind_field;
  wire [4:0]  ind_num;
  wire        ind_zero;
  wire        ind_down;
  wire        ind_up;
  wire        ind_res;
  wire        next_direct;
  wire [6:0]  dir_hit;
  reg         next_dec_valid;
  reg         next_bit_reversed;
  reg         next_to_memory;
  reg  [15:0] next_low_imm;
  reg  [7:0]  next_upper_byte;
  reg  [23:0] next_imm24;
  reg         next_direct_mode;
  reg         next_sel_in_buf;
  reg         next_sel_out_buf;
  reg         next_sel_par_data;
  reg         next_sel_par_ptr;
  reg         next_sel_par_data2;
  reg         next_sel_par_int;
  reg         next_sel_ctrl_word;
  reg         next_sel_debug;
  reg         next_sel_reserved;
  reg  [4:0]  next_ptr_num;
  reg         next_ptr_zero;
  reg         next_ptr_step_down;
  reg         next_ptr_step_up;
  reg         next_ptr_reserved;
  genvar      gi;
  assign ptr_field = insn_word[`DMOFD_PTR_MSB:`DMOFD_PTR_LSB];
  assign ind_field = insn_word[`DMOFD_IND_MSB:`DMOFD_IND_LSB];
  assign next_direct = (ptr_field == `DMOFD_PTR_DIRECT);

  // Same bits serve pointer or direct selector, decoded both ways
  dmofd_ind_dec u_ind
  (
    .code      (ind_field),
    .ptr_num   (ind_num),
    .is_zero   (ind_zero),
    .step_down (ind_down),
    .step_up   (ind_up),
    .reserved  (ind_res)
  );

  function sel_hit;
    input [4:0] code;
    input [4:0] want;
    input       direct;
    begin
      sel_hit = direct && (code == want);
    end
  endfunction

  // Packed select codes, in the order of the select outputs
  localparam [34:0] DIR_CODES = {`DMOFD_SEL_IN_BUF,
                                 `DMOFD_SEL_OUT_BUF,
                                 `DMOFD_SEL_PAR_DATA,
                                 `DMOFD_SEL_PAR_PTR,
                                 `DMOFD_SEL_PAR_DATA2,
                                 `DMOFD_SEL_PAR_INT,
                                 `DMOFD_SEL_CTRL_WORD};

  // One comparator per I/O register keeps the reserved test exact
  generate
    for (gi = 0; gi < 7; gi = gi + 1)
    begin : g_dir
      assign dir_hit[gi] = sel_hit(ind_field, DIR_CODES[gi*5 +: 5], next_direct);
    end
  endgenerate

  always @*
  begin
    next_dec_valid     = insn_valid;
    next_bit_reversed  = insn_word[`DMOFD_REV_BIT];
    next_to_memory     = insn_word[`DMOFD_DIR_BIT];
    next_low_imm       = insn_word[`DMOFD_LOW_IMM_MSB:`DMOFD_LOW_IMM_LSB];
    next_upper_byte    = insn_word[`DMOFD_UPPER_BYTE_MSB:`DMOFD_UPPER_BYTE_LSB];
    next_imm24         = {next_upper_byte, next_low_imm};
    next_direct_mode   = next_direct;

    next_sel_in_buf    = dir_hit[6];
    next_sel_out_buf   = dir_hit[5];
    next_sel_par_data  = dir_hit[4];
    next_sel_par_ptr   = dir_hit[3];
    next_sel_par_data2 = dir_hit[2];
    next_sel_par_int   = dir_hit[1];
    next_sel_ctrl_word = dir_hit[0];
    // Debug slot flagged apart so software misuse is visible
    next_sel_debug     = sel_hit(ind_field, `DMOFD_SEL_DEBUG, next_direct);
    next_sel_reserved  = next_direct && !(|dir_hit);

    // Indirect outputs stay quiet whenever the pointer field is zero (direct mode), whatever the selector code
    next_ptr_num       = 5'h00;
    next_ptr_zero      = 1'b0;
    next_ptr_step_down = 1'b0;
    next_ptr_step_up   = 1'b0;
    next_ptr_reserved  = 1'b0;
    if (!next_direct)
    begin
      next_ptr_num       = ind_num;
      next_ptr_zero      = ind_zero;
      next_ptr_step_down = ind_down;
      next_ptr_step_up   = ind_up;
      next_ptr_reserved  = ind_res;
    end
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dec_valid            <= `DMOFD_RST_FLAG;
      bit_reversed         <= `DMOFD_RST_FLAG;
      to_memory            <= `DMOFD_RST_FLAG;
      low_imm              <= `DMOFD_RST_LOW_IMM;
      upper_immediate_byte <= `DMOFD_RST_UPPER_BYTE;
      imm24                <= `DMOFD_RST_IMM24;
    end
    else
    begin
      // Fields latch every cycle; dec_valid qualifies them
      dec_valid            <= next_dec_valid;
      bit_reversed         <= next_bit_reversed;
      to_memory            <= next_to_memory;
      low_imm              <= next_low_imm;
      upper_immediate_byte <= next_upper_byte;
      imm24                <= next_imm24;
    end
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      direct_mode                  <= `DMOFD_RST_FLAG;
      sel_in_buf                   <= `DMOFD_RST_FLAG;
      sel_out_buf                  <= `DMOFD_RST_FLAG;
      sel_par_data                 <= `DMOFD_RST_FLAG;
      sel_par_ptr                  <= `DMOFD_RST_FLAG;
      sel_second_parallel_data_reg <= `DMOFD_RST_FLAG;
      sel_par_int                  <= `DMOFD_RST_FLAG;
      sel_ctrl_word                <= `DMOFD_RST_FLAG;
      sel_debug                    <= `DMOFD_RST_FLAG;
      sel_reserved                 <= `DMOFD_RST_FLAG;
    end
    else
    begin
      direct_mode                  <= next_direct_mode;
      sel_in_buf                   <= next_sel_in_buf;
      sel_out_buf                  <= next_sel_out_buf;
      sel_par_data                 <= next_sel_par_data;
      sel_par_ptr                  <= next_sel_par_ptr;
      sel_second_parallel_data_reg <= next_sel_par_data2;
      sel_par_int                  <= next_sel_par_int;
      sel_ctrl_word                <= next_sel_ctrl_word;
      sel_debug                    <= next_sel_debug;
      sel_reserved                 <= next_sel_reserved;
    end
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr_num       <= `DMOFD_RST_PTR_NUM;
      ptr_zero      <= `DMOFD_RST_FLAG;
      ptr_step_down <= `DMOFD_RST_FLAG;
      ptr_step_up   <= `DMOFD_RST_FLAG;
      ptr_reserved  <= `DMOFD_RST_FLAG;
    end
    else
    begin
      ptr_num       <= next_ptr_num;
      ptr_zero      <= next_ptr_zero;
      ptr_step_down <= next_ptr_step_down;
      ptr_step_up   <= next_ptr_step_up;
      ptr_reserved  <= next_ptr_reserved;
    end
  end
endmodule
`default_nettype wire

// ==== core/dmofd_map.vh ====
// Field positions, selector codes and reset values for the data-move operand decoder
`ifndef DMOFD_MAP_VH
`define DMOFD_MAP_VH
`define DMOFD_LOW_IMM_LSB      0
`define DMOFD_LOW_IMM_MSB      15
`define DMOFD_UPPER_BYTE_LSB   21
`define DMOFD_UPPER_BYTE_MSB   28
`define DMOFD_DIR_BIT          24
`define DMOFD_REV_BIT          10
`define DMOFD_PTR_LSB          5
`define DMOFD_PTR_MSB          9
`define DMOFD_IND_LSB          0
`define DMOFD_IND_MSB          4
`define DMOFD_PTR_DIRECT       5'h00
`define DMOFD_SEL_IN_BUF       5'h04
`define DMOFD_SEL_OUT_BUF      5'h05
`define DMOFD_SEL_PAR_DATA     5'h06
`define DMOFD_SEL_PAR_PTR      5'h0E
`define DMOFD_SEL_PAR_DATA2    5'h14
`define DMOFD_SEL_PAR_INT      5'h16
`define DMOFD_SEL_CTRL_WORD    5'h1E
`define DMOFD_SEL_DEBUG        5'h0A
`define DMOFD_IND_ZERO         5'h10
`define DMOFD_IND_STEP_DOWN    5'h16
`define DMOFD_IND_STEP_UP      5'h17
`define DMOFD_RST_WORD         32'h00000000
`define DMOFD_RST_FLAG         1'b0
`define DMOFD_RST_LOW_IMM      16'h0000
`define DMOFD_RST_UPPER_BYTE   8'h00
`define DMOFD_RST_IMM24        24'h000000
`define DMOFD_RST_PTR_NUM      5'h00
`endif

// ==== core/dmofd_ind_dec.v ====
// Register-indirect selector decoder
`timescale 1ns/1ps
`default_nettype none
`include "dmofd_map.vh"
module dmofd_ind_dec
(
  input  wire [4:0] code,
  output reg  [4:0] ptr_num,
  output reg        is_zero,
  output reg        step_down,
  output reg        step_up,
  output reg        reserved
);
  always @*
  begin
    ptr_num   = 5'h00;
    is_zero   = 1'b0;
    step_down = 1'b0;
    step_up   = 1'b0;
    reserved  = 1'b0;
    // Pointer numbering skips pc slot, hence the offset ranges
    if (code >= 5'h01 && code <= 5'h0E)
      ptr_num = code;
    else if (code >= 5'h11 && code <= 5'h15)
      ptr_num = code - 5'h02;
    else if (code == 5'h18 || code == 5'h19)
      ptr_num = code - 5'h04;
    else if (code == 5'h1D)
      ptr_num = 5'h16;
    else if (code == `DMOFD_IND_ZERO)
      is_zero = 1'b1;
    else if (code == `DMOFD_IND_STEP_DOWN)
      step_down = 1'b1;
    else if (code == `DMOFD_IND_STEP_UP)
      step_up = 1'b1;
    else
      reserved = 1'b1;
  end
endmodule
`default_nettype wire

// ==== tb/dmofd_monitor.sv ====
// Checker on the decoder output ports
`timescale 1ns/1ps
`default_nettype none
module dmofd_monitor (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [31:0] insn_word,
  input wire logic        bit_reversed,
  input wire logic        to_memory,
  input wire logic [15:0] low_imm,
  input wire logic [7:0]  upper_immediate_byte,
  input wire logic [23:0] imm24,
  input wire logic        direct_mode,
  input wire logic        sel_ctrl_word,
  input wire logic        sel_debug,
  input wire logic        sel_reserved,
  input wire logic        ptr_step_up
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // First edge after reset still shows the cleared outputs
  sequence s_live;
    $past(rst_n);
  endsequence
  a_rev_flag: assert property (s_live |-> bit_reversed == $past(insn_word[10]))
    else $error("bit_reversed wrong");
  a_low_imm: assert property (s_live |-> low_imm == $past(insn_word[15:0]))
    else $error("low_imm wrong");
  a_upper_byte: assert property (s_live |->
    upper_immediate_byte == $past(insn_word[28:21])) else $error("upper byte wrong");
  a_imm_join: assert property (imm24 == {upper_immediate_byte, low_imm})
    else $error("imm24 wrong");
  a_direct_gate: assert property (s_live |->
    (direct_mode == ($past(insn_word[9:5]) == 5'h00)) && (direct_mode || !sel_reserved))
    else $error("direct gate wrong");
  a_ctrl_sel: assert property (s_live |->
    sel_ctrl_word == (direct_mode && ($past(insn_word[4:0]) == 5'h1E)))
    else $error("ctrl select wrong");
  a_debug_code: assert property (s_live |->
    sel_debug == (direct_mode && ($past(insn_word[4:0]) == 5'h0A)))
    else $error("debug select wrong");
  a_dir_bit: assert property (s_live |-> to_memory == $past(insn_word[24]))
    else $error("to_memory wrong");
  a_step_up: assert property (s_live |->
    ptr_step_up == (!direct_mode && ($past(insn_word[4:0]) == 5'h17)))
    else $error("step up wrong");
endmodule
bind dmofd_top dmofd_monitor u_mon (.clk_sys, .rst_n, .insn_word, .bit_reversed, .to_memory,
  .low_imm, .upper_immediate_byte, .imm24, .direct_mode, .sel_ctrl_word, .sel_debug,
  .sel_reserved, .ptr_step_up);
`default_nettype wire

// ==== tb/dmofd_fetch.sv ====
// Instruction fetch model feeding the decoder
`timescale 1ns/1ps
`default_nettype none
module dmofd_fetch (
  input  wire logic        clk_sys,
  output var  logic        insn_valid,
  output var  logic [31:0] insn_word
);
  initial
  begin
    insn_valid = 1'b0;
    insn_word = 32'h0;
  end
  // Idle word inverted so a stale word never decodes right
  task automatic issue(input logic [31:0] w);
    @(posedge clk_sys);
    #1 insn_valid = 1'b1;
    insn_word = w;
    @(posedge clk_sys);
    #1 insn_valid = 1'b0;
    insn_word = ~w;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the operand field decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic insn_valid, dec_valid, bit_reversed, to_memory, direct_mode, sel_in_buf, sel_out_buf;
  logic sel_par_data, sel_par_ptr, sel_second_parallel_data_reg, sel_par_int, sel_ctrl_word;
  logic sel_debug, sel_reserved, ptr_zero, ptr_step_down, ptr_step_up, ptr_reserved;
  logic [31:0] insn_word;
  logic [15:0] low_imm;
  logic [7:0]  upper_immediate_byte;
  logic [23:0] imm24;
  logic [4:0]  ptr_num;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  dmofd_fetch u_fetch (.clk_sys, .insn_valid, .insn_word);
  dmofd_top dut (.clk_sys, .rst_n, .insn_valid, .insn_word, .dec_valid, .bit_reversed,
    .to_memory, .low_imm, .upper_immediate_byte, .imm24, .direct_mode, .sel_in_buf,
    .sel_out_buf, .sel_par_data, .sel_par_ptr, .sel_second_parallel_data_reg, .sel_par_int,
    .sel_ctrl_word, .sel_debug, .sel_reserved, .ptr_num, .ptr_zero, .ptr_step_down,
    .ptr_step_up, .ptr_reserved);
  always #12.5 clk_sys = ~clk_sys;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_imm;
    logic [31:0] w;
    for (int k = 0; k < 2; k++)
    begin
      w = k ? 32'hE54A381C : 32'h1AB5C7E3;
      u_fetch.issue(w);
      chk("dec_valid", 1, dec_valid);
      chk("rev", w[10], bit_reversed);
      chk("low", w[15:0], low_imm);
      chk("upper", w[28:21], upper_immediate_byte);
      chk("imm24", {w[28:21], w[15:0]}, imm24);
      chk("to_mem", w[24], to_memory);
    end
    // Idle word follows with insn_valid low
    @(posedge clk_sys);
    #1 chk("dec_valid", 0, dec_valid);
    $display("t_imm done");
  endtask
  task automatic t_sel;
    logic [6:0] e;
    for (int c = 0; c < 32; c++)
    begin
      e = c == 4 ? 7'h40 : c == 5 ? 7'h20 : c == 6 ? 7'h10 : c == 14 ? 7'h08 : 7'h00;
      e = c == 20 ? 7'h04 : c == 22 ? 7'h02 : c == 30 ? 7'h01 : e;
      u_fetch.issue(c);
      chk("sel", e, {sel_in_buf, sel_out_buf, sel_par_data, sel_par_ptr,
        sel_second_parallel_data_reg, sel_par_int, sel_ctrl_word});
      chk("direct", 1, direct_mode);
      chk("debug", c == 10, sel_debug);
      chk("reserved", e == 7'h00, sel_reserved);
    end
    u_fetch.issue(32'h3E);
    chk("gate", 0, {direct_mode, sel_ctrl_word, sel_reserved});
    $display("t_sel done");
  endtask
  task automatic t_ind;
    int n;
    for (int c = 0; c < 32; c++)
    begin
      n = (c > 0 && c < 15) ? c : (c > 16 && c < 22) ? c - 2 : 0;
      n = c == 24 ? 20 : c == 25 ? 21 : c == 29 ? 22 : n;
      u_fetch.issue(32'h20 | c);
      chk("ptr", n, ptr_num);
      chk("ptr_kind",
        {c == 16, c == 22, c == 23, n == 0 && !(c == 16 || c == 22 || c == 23)},
        {ptr_zero, ptr_step_down, ptr_step_up, ptr_reserved});
      chk("ind_quiet", 0, {direct_mode, sel_reserved, sel_debug});
    end
    $display("t_ind done");
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      n_errors++;
      test_done;
    end
  end
  initial
  begin
    repeat (10) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    t_imm;
    t_sel;
    t_ind;
    test_done;
  end
endmodule
`default_nettype wire
